// ==== nefu_regs.vh ====
`ifndef NEFU_REGS_VH
`define NEFU_REGS_VH
// energies and log values are signed Q16.16 throughout
`define NEFU_BANDS        5'd20
`define NEFU_LAST_BAND    5'd19
`define NEFU_NB_FIRST     5'd1
`define NEFU_NB_LAST      5'd16
`define NEFU_NOISE_RESET  32'sh000000E5
`define NEFU_LTAVG_RESET  32'sh00000000
`define NEFU_K0P9         32'sh0000E666
`define NEFU_K0P1         32'sh0000199A
`define NEFU_K0P98        32'sh0000FAE1
`define NEFU_K0P02        32'sh0000051F
`define NEFU_K3P0         32'sh00030000
`define NEFU_K0P8         32'sh0000CCCD
`define NEFU_K0P2         32'sh00003333
`define NEFU_K0P04        32'sh00000A3D
`define NEFU_K0P08        32'sh0000147B
`define NEFU_K2P0         32'sh00020000
`define NEFU_K10          32'sh000A0000
`define NEFU_K30          32'sh001E0000
`define NEFU_K0P03        32'sh000007AE
`define NEFU_K0P064       32'sh00001062
`define NEFU_K0P75        32'sh0000C000
`define NEFU_K0P999       32'sh0000FFBE
`define NEFU_K1P0         32'sh00010000
`define NEFU_THIRD        32'sh00005555
`define NEFU_TH_WB        32'sh0000851F
`define NEFU_TH_NB        32'sh0000A666
`define NEFU_DB_PER_LOG2  32'sh000302A3
`define NEFU_HARM_HIGH    16'h0032
`define NEFU_HARM_MID     16'h001E
`define NEFU_HARM_LOW     16'h0014
`define NEFU_INI_LIMIT    8'h96
`define NEFU_INI_FRAMES   8'h02
`define NEFU_PITCH_UNST   10'h00C
`endif

// ==== nefu_core.v ====
// Behaviour
// - total noise is dB of previous band sum
// - reset presets band noise to 0.0035
// - candidate mixes prior estimate and band energies
// - band estimate only moves downward here
// - variation is absolute frame energy difference
// - smoothed variation, clipped input, floored 0.1
// - first two frames load trackers, clear features
// - smoothed energy 0.8 old plus 0.2 new
// - upper tracker decays 0.04, capped by energy
// - lower tracker rises, harmonic boost when allowed
// - excess-driven extra rise, then capped by energy
// - long-term minimum with 0.03 or 0.02 factor
// - dynamics low-pass of tracker difference
// - second-stage decision inputs ignore activity detector
// - pitch count sums lag differences, stable below 12
// - low voicing forces pitch count to 12
// - per-band long-term average over active range
// - average factor from relative energy, capped
// - non-stationarity from band ratio product
// - voicing is mean of two correlations plus correction
// - residual ratio of order two over sixteen
`include "nefu_regs.vh"
module nefu_core (
    // clock and reset
    input  wire                clk,
    input  wire                reset,
    // frame inputs, stable from strobe until done
    input  wire                frameStrobe,
    input  wire                wideband,
    input  wire [639:0]        bandFirstFlat,
    input  wire [639:0]        bandSecondFlat,
    input  wire signed [31:0]  frameEnergy,
    input  wire signed [31:0]  relEnergy,
    input  wire [7:0]          lagFirst,
    input  wire [7:0]          lagSecond,
    input  wire signed [31:0]  normCorr0,
    input  wire signed [31:0]  normCorr1,
    input  wire signed [31:0]  normCorr2,
    input  wire signed [31:0]  noiseCorr,
    input  wire [15:0]         harmCount,
    input  wire [31:0]         residOrder2,
    input  wire [31:0]         residOrder16,
    // status
    output wire                busy,
    output reg                 done,
    // noise estimate
    output wire [639:0]        noiseBandFlat,
    output reg signed [31:0]   totalNoise,
    // energy features
    output reg signed [31:0]   energyVariation,
    output reg signed [31:0]   smoothVariation,
    output reg signed [31:0]   smoothEnergy,
    output reg signed [31:0]   upperEnvelope,
    output reg signed [31:0]   lowerEnvelope,
    output reg signed [31:0]   longTermMin,
    output reg signed [31:0]   energyDynamics,
    // second-stage decision parameters
    output reg [9:0]           pitchStabilityCount,
    output reg                 pitchStable,
    output reg signed [31:0]   nonStationarity,
    output reg signed [31:0]   voicing,
    output reg signed [31:0]   residRatio
);
    localparam S_IDLE  = 2'd0;
    localparam S_BAND  = 2'd1;
    localparam S_FRAME = 2'd2;

    // Q16.16 product, fractional bits dropped
    function signed [31:0] smul;
        input signed [31:0] a;
        input signed [31:0] b;
        reg signed [63:0] p;
        begin
            p = a * b;
            smul = p[47:16];
        end
    endfunction

    // shared log unit: log2 by leading one plus linear mantissa
    function signed [31:0] log2q;
        input [31:0] x;
        integer k;
        reg [4:0] pos;
        reg [31:0] norm;
        begin
            pos = 5'd0;
            for (k = 0; k < 32; k = k + 1) begin
                if (x[k])
                    pos = k[4:0];
            end
            norm = x << (5'd31 - pos);
            log2q = $signed({11'h000, pos, 16'h0000}) - 32'sh00100000 + $signed({16'h0000, norm[30:15]});
        end
    endfunction

    // signed minimum, shared by the clip and tracker steps
    function signed [31:0] smin;
        input signed [31:0] a;
        input signed [31:0] b;
        begin
            smin = (a < b) ? a : b;
        end
    endfunction

    // sequencer state and per-band memories
    reg [1:0]          state_reg;
    reg [4:0]          band_reg;
    reg [7:0]          iniCount_reg;
    reg [7:0]          prevLag_reg;
    reg signed [31:0]  prevEnergy_reg;
    reg signed [31:0]  noiseSum_reg;
    reg signed [31:0]  nonstatAcc_reg;
    reg signed [31:0]  noiseEst_reg [0:19];
    reg signed [31:0]  prevSecond_reg [0:19];
    reg signed [31:0]  ltAvg_reg [0:19];

    // flat output bus, band i from bit i*32 upward
    genvar g;
    generate
        for (g = 0; g < 20; g = g + 1) begin : gOut
            assign noiseBandFlat[g*32 +: 32] = noiseEst_reg[g];
        end
    endgenerate

    // busy covers the band cycles and the frame cycle
    assign busy = (state_reg != S_IDLE);

    // per-band datapath
    wire signed [31:0] eFirst  = $signed(bandFirstFlat[band_reg*32 +: 32]);
    wire signed [31:0] eSecond = $signed(bandSecondFlat[band_reg*32 +: 32]);
    wire signed [31:0] nOld    = noiseEst_reg[band_reg];
    // candidate for the downward update
    wire signed [31:0] mix     = (prevSecond_reg[band_reg] >>> 2)
                               + smul(`NEFU_K0P75, eFirst + (eSecond >>> 1));
    wire signed [31:0] nCand   = smul(`NEFU_K0P9, nOld) + smul(`NEFU_K0P1, mix);

    // long-term average and its ratio to the current mean
    wire signed [31:0] bandMean = (eFirst >>> 1) + (eSecond >>> 1);
    wire signed [31:0] avgOld  = ltAvg_reg[band_reg];
    wire signed [31:0] bigger  = (bandMean > avgOld) ? bandMean : avgOld;
    wire signed [31:0] smaller = (bandMean > avgOld) ? avgOld : bandMean;
    // ratio taken in the log domain so the product becomes a sum
    wire signed [31:0] ratioLog = log2q(bigger + `NEFU_K1P0) - log2q(smaller + `NEFU_K1P0);
    wire signed [31:0] relPos  = (relEnergy < 0) ? 32'sh00000000 : relEnergy;
    wire signed [31:0] alphaRaw = smul(`NEFU_K0P064, relPos) + `NEFU_K0P75;
    wire signed [31:0] alpha   = smin(alphaRaw, `NEFU_K0P999);
    wire signed [31:0] avgNew  = smul(alpha, avgOld) + smul(`NEFU_K1P0 - alpha, bandMean);
    wire inRange = wideband ? 1'b1 : (band_reg >= `NEFU_NB_FIRST && band_reg <= `NEFU_NB_LAST);

    // frame-level datapath, evaluated in the frame state
    reg signed [31:0] varNow, svNext, seNext, upNext, lo1, lo2, lo3, ex1, ex2, ltNext, dynNext;
    reg               fastMin;
    reg [8:0]         lagDiffA, lagDiffB;
    reg [9:0]         pcRaw;
    reg signed [31:0] corrMean;
    always @* begin
        varNow = (prevEnergy_reg > frameEnergy) ? prevEnergy_reg - frameEnergy
                                                : frameEnergy - prevEnergy_reg;
        svNext = smul(`NEFU_K0P98, smoothVariation) + smul(`NEFU_K0P02, smin(`NEFU_K3P0, varNow));
        if (svNext < `NEFU_K0P1)
            svNext = `NEFU_K0P1;

        // energy smoothing and upper tracker
        seNext = smul(`NEFU_K0P8, smoothEnergy) + smul(`NEFU_K0P2, frameEnergy);
        upNext = smin(upperEnvelope - `NEFU_K0P04, frameEnergy);

        // lower tracker: steady rise, harmonic boost, then excess rise
        lo1 = lowerEnvelope + `NEFU_K0P08;
        ex1 = prevEnergy_reg - lo1;
        if (harmCount > `NEFU_HARM_HIGH && iniCount_reg < `NEFU_INI_LIMIT
            && (prevEnergy_reg - seNext) < `NEFU_K3P0)
            lo1 = lo1 + smin(`NEFU_K2P0, smul(`NEFU_K0P1, ex1));
        ex2 = prevEnergy_reg - lo1;
        if (ex2 > `NEFU_K30 && harmCount < `NEFU_HARM_LOW)
            lo2 = lo1 + smul(`NEFU_K0P2, ex2);
        else if (ex2 > `NEFU_K10)
            lo2 = lo1 + `NEFU_K0P08;
        else
            lo2 = lo1;
        lo3 = smin(lo2, frameEnergy);

        // minimum adapts faster after strong attacks
        fastMin = (harmCount > `NEFU_HARM_MID && (prevEnergy_reg - lo3) > `NEFU_K30)
               || (harmCount > `NEFU_HARM_MID && iniCount_reg < `NEFU_INI_LIMIT)
               || ((longTermMin - lo3) > `NEFU_K30);
        ltNext = longTermMin + smul(fastMin ? `NEFU_K0P03 : `NEFU_K0P02, lo3 - longTermMin);
        dynNext = smul(`NEFU_K0P9, energyDynamics) + smul(`NEFU_K0P1, upNext - lo3);

        // pitch stability from this frame's lags and the previous frame's second lag
        lagDiffA = (lagFirst > prevLag_reg) ? {1'b0, lagFirst - prevLag_reg} : {1'b0, prevLag_reg - lagFirst};
        lagDiffB = (lagSecond > lagFirst) ? {1'b0, lagSecond - lagFirst} : {1'b0, lagFirst - lagSecond};
        pcRaw = {1'b0, lagDiffA} + {1'b0, lagDiffB};
        // third is slightly low in fixed point, matters only at the threshold
        corrMean = smul(`NEFU_THIRD, normCorr0 + normCorr1 + normCorr2) + noiseCorr;
    end

    // all state: band loop and frame step
    integer i;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= S_IDLE;
            band_reg <= 5'd0;
            iniCount_reg <= 8'h00;
            prevLag_reg <= 8'h00;
            prevEnergy_reg <= 32'sh00000000;
            noiseSum_reg <= 32'sh00000000;
            nonstatAcc_reg <= 32'sh00000000;
            for (i = 0; i < 20; i = i + 1) begin
                noiseEst_reg[i] <= `NEFU_NOISE_RESET;
                prevSecond_reg[i] <= 32'sh00000000;
                ltAvg_reg[i] <= `NEFU_LTAVG_RESET;
            end
            done <= 1'b0;
            totalNoise <= 32'sh00000000;
            energyVariation <= 32'sh00000000;
            smoothVariation <= 32'sh00000000;
            smoothEnergy <= 32'sh00000000;
            upperEnvelope <= 32'sh00000000;
            lowerEnvelope <= 32'sh00000000;
            longTermMin <= 32'sh00000000;
            energyDynamics <= 32'sh00000000;
            pitchStabilityCount <= 10'h000;
            pitchStable <= 1'b0;
            nonStationarity <= 32'sh00000000;
            voicing <= 32'sh00000000;
            residRatio <= 32'sh00000000;
        end else begin
            // done is a single-cycle pulse
            done <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    // strobes while busy are dropped, so each frame updates once
                    if (frameStrobe) begin
                        state_reg <= S_BAND;
                        band_reg <= 5'd0;
                        noiseSum_reg <= 32'sh00000000;
                        nonstatAcc_reg <= 32'sh00000000;
                    end
                end
                // one band per cycle keeps a single multiplier set
                S_BAND: begin
                    noiseSum_reg <= noiseSum_reg + nOld;
                    if (nCand < nOld)
                        noiseEst_reg[band_reg] <= nCand;
                    // second analysis kept for next frame's mix
                    prevSecond_reg[band_reg] <= eSecond;
                    if (inRange) begin
                        nonstatAcc_reg <= nonstatAcc_reg + ratioLog;
                        ltAvg_reg[band_reg] <= avgNew;
                    end
                    if (band_reg == `NEFU_LAST_BAND)
                        state_reg <= S_FRAME;
                    else
                        band_reg <= band_reg + 5'd1;
                end
                S_FRAME: begin
                    totalNoise <= smul(log2q(noiseSum_reg), `NEFU_DB_PER_LOG2);
                    energyVariation <= varNow;
                    // trackers follow the energy until two frames have passed
                    if (iniCount_reg < `NEFU_INI_FRAMES) begin
                        upperEnvelope <= frameEnergy;
                        lowerEnvelope <= frameEnergy;
                        longTermMin <= frameEnergy;
                        smoothEnergy <= frameEnergy;
                        smoothVariation <= 32'sh00000000;
                        energyDynamics <= 32'sh00000000;
                    end else begin
                        smoothVariation <= svNext;
                        smoothEnergy <= seNext;
                        upperEnvelope <= upNext;
                        lowerEnvelope <= lo3;
                        longTermMin <= ltNext;
                        energyDynamics <= dynNext;
                    end
                    // saturates so a long run never re-enters init
                    if (iniCount_reg != 8'hFF)
                        iniCount_reg <= iniCount_reg + 8'h01;
                    prevEnergy_reg <= frameEnergy;
                    prevLag_reg <= lagSecond;
                    // decision inputs built only from these parameters
                    if (corrMean < (wideband ? `NEFU_TH_WB : `NEFU_TH_NB)) begin
                        pitchStabilityCount <= `NEFU_PITCH_UNST;
                        pitchStable <= 1'b0;
                    end else begin
                        pitchStabilityCount <= pcRaw;
                        pitchStable <= (pcRaw < `NEFU_PITCH_UNST);
                    end
                    nonStationarity <= nonstatAcc_reg;
                    voicing <= ((normCorr0 + normCorr1) >>> 1) + noiseCorr;
                    // log-domain ratio avoids a divider
                    residRatio <= log2q(residOrder2) - log2q(residOrder16);
                    done <= 1'b1;
                    state_reg <= S_IDLE;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule

// ==== nefu_checker.sv ====
`include "nefu_regs.vh"
module nefu_checker (
    // clock and reset
    input wire logic               clk,
    input wire logic               reset,
    // frame inputs
    input wire logic               frameStrobe,
    input wire logic               wideband,
    input wire logic signed [31:0] frameEnergy,
    input wire logic signed [31:0] normCorr0,
    input wire logic signed [31:0] normCorr1,
    input wire logic signed [31:0] normCorr2,
    input wire logic signed [31:0] noiseCorr,
    // block outputs
    input wire logic               busy,
    input wire logic               done,
    input wire logic [639:0]       noiseBandFlat,
    input wire logic signed [31:0] upperEnvelope,
    input wire logic signed [31:0] energyVariation,
    input wire logic [9:0]         pitchStabilityCount,
    input wire logic               pitchStable,
    input wire logic signed [31:0] voicing
);
    logic [1:0]         frameCnt_reg;
    logic signed [31:0] lastEnergy_reg;
    logic signed [33:0] corrSum;
    logic signed [33:0] voiceExp;
    logic signed [31:0] diffE;
    logic               lowVoice;
    // sums scaled by three so the mean needs no divide
    assign corrSum  = normCorr0 + normCorr1 + normCorr2 + 3 * noiseCorr;
    assign lowVoice = corrSum < 3 * (wideband ? `NEFU_TH_WB : `NEFU_TH_NB);
    assign voiceExp = ((normCorr0 + normCorr1) >>> 1) + noiseCorr;
    assign diffE    = lastEnergy_reg - frameEnergy;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            frameCnt_reg   <= 2'd0;
            lastEnergy_reg <= 32'sh00000000;
        end else if (done) begin
            frameCnt_reg   <= (frameCnt_reg == 2'd2) ? 2'd2 : frameCnt_reg + 2'd1;
            lastEnergy_reg <= frameEnergy;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence accepted; frameStrobe && !busy; endsequence
    sequence busyRun; (busy && !done) [*8]; endsequence
    AST_DONE_LATENCY: assert property (accepted |-> ##22 done)
        else $error("done not on time");
    AST_BUSY_RUN: assert property (accepted |=> busyRun)
        else $error("busy dropped early");
    AST_DONE_PULSE: assert property (done |=> !done)
        else $error("done longer than one cycle");
    AST_RESET_NOISE: assert property ($fell(reset) |-> noiseBandFlat == {20{`NEFU_NOISE_RESET}})
        else $error("band noise not preset");
    AST_PITCH_STABLE: assert property (done |-> pitchStable == (pitchStabilityCount < 10'd12))
        else $error("stable flag wrong");
    AST_LOW_VOICING: assert property (done && lowVoice |-> pitchStabilityCount == `NEFU_PITCH_UNST)
        else $error("low voicing not forced");
    AST_VOICING: assert property (done |-> voicing >= voiceExp - 4 && voicing <= voiceExp + 4)
        else $error("voicing wrong");
    AST_UPPER: assert property (done && frameCnt_reg == 2'd2 |-> upperEnvelope ==
        (($past(upperEnvelope) - `NEFU_K0P04 < frameEnergy) ? $past(upperEnvelope) - `NEFU_K0P04 : frameEnergy))
        else $error("upper tracker wrong");
    AST_VARIATION: assert property (done |-> energyVariation == (diffE < 0 ? -diffE : diffE))
        else $error("variation wrong");
endmodule
bind nefu_core nefu_checker chk (.clk, .reset, .frameStrobe, .wideband, .frameEnergy, .normCorr0, .normCorr1,
    .normCorr2, .noiseCorr, .busy, .done, .noiseBandFlat, .upperEnvelope, .energyVariation,
    .pitchStabilityCount, .pitchStable, .voicing);

// ==== nefu_upstream.sv ====
module nefu_upstream (
    // clock
    input wire logic           clk,
    // frame inputs to the block
    output logic               frameStrobe,
    output logic               wideband,
    output logic [639:0]       bandFirstFlat,
    output logic [639:0]       bandSecondFlat,
    output logic signed [31:0] frameEnergy,
    output logic signed [31:0] relEnergy,
    output logic [7:0]         lagFirst,
    output logic [7:0]         lagSecond,
    output logic signed [31:0] normCorr0,
    output logic signed [31:0] normCorr1,
    output logic signed [31:0] normCorr2,
    output logic signed [31:0] noiseCorr,
    output logic [15:0]        harmCount,
    output logic [31:0]        residOrder2,
    output logic [31:0]        residOrder16
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        frameStrobe = 1'b0;
        wideband = 1'b1;
        bandFirstFlat = 640'h00010000 << 160;
        bandSecondFlat = 640'h0;
        {frameEnergy, relEnergy, residOrder2} = 96'h0;
        {lagFirst, lagSecond, harmCount} = 32'h0;
        {normCorr0, normCorr1, normCorr2} = {3{32'h00008000}};
        noiseCorr = 32'h00001000;
        residOrder16 = 32'h00010000;
    end
    // inputs stay put until the next frame, strobe lasts one cycle
    task automatic send(input logic [31:0] e, input logic [7:0] la, input logic [7:0] lb, input logic wb,
                        input logic [31:0] r2, input bit extra);
        @(negedge clk);
        {frameEnergy, lagFirst, lagSecond, wideband, residOrder2} = {e, la, lb, wb, r2};
        frameStrobe = 1'b1;
        @(negedge clk);
        frameStrobe = 1'b0;
        if (extra) begin
            // stray strobe while busy, only when a scenario asks
            repeat (4) @(negedge clk);
            frameStrobe = 1'b1;
            @(negedge clk);
            frameStrobe = 1'b0;
        end
    endtask
endmodule

// ==== noise_energy_feature_update_tb.sv ====
module noise_energy_feature_update_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic frameStrobe, wideband, busy, done, pitchStable;
    logic [639:0] bandFirstFlat, bandSecondFlat, noiseBandFlat;
    logic signed [31:0] frameEnergy, relEnergy, normCorr0, normCorr1, normCorr2, noiseCorr;
    logic [7:0] lagFirst, lagSecond;
    logic [15:0] harmCount;
    logic [31:0] residOrder2, residOrder16;
    logic [9:0] pitchStabilityCount;
    logic signed [31:0] totalNoise, energyVariation, smoothVariation, smoothEnergy, upperEnvelope;
    logic signed [31:0] lowerEnvelope, longTermMin, energyDynamics, nonStationarity, voicing, residRatio;
    int n_mismatch = 0;
    int checked = 0;
    nefu_core uut (.*);
    nefu_upstream up (.*);
    initial forever #4 clk = ~clk;
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // fixed-point results may be off by rounding, log-based results by the linear mantissa approximation
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input int tol);
        int d;
        d = $signed(got - exp);
        checked++;
        if ($isunknown(got) || d > tol || -d > tol) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic frame(input logic [31:0] e, input logic [7:0] la, lb, input logic wb, r2, input bit x);
        int i;
        up.send(e, la, lb, wb, x ? 32'h00040000 : 32'h00010000, x);
        for (i = 0; done !== 1'b1 && i < 40; i++) @(negedge clk);
        if (done !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    task automatic t_reset;
        for (int i = 0; i < 20; i++) cmp(noiseBandFlat[i*32+:32], 32'h000000E5, 0);
        cmp({totalNoise, upperEnvelope} != 64'h0, 0, 0);
    endtask
    task automatic t_init;
        frame(32'h00140000, 8'd40, 8'd45, 1'b1, 1'b0, 1'b1);
        cmp(energyVariation, 32'h00140000, 0);
        cmp(upperEnvelope, 32'h00140000, 0);
        cmp(lowerEnvelope, 32'h00140000, 0);
        cmp(longTermMin, 32'h00140000, 0);
        cmp(smoothEnergy, 32'h00140000, 0);
        cmp({smoothVariation, energyDynamics} != 64'h0, 0, 0);
        cmp(residRatio, 32'h00020000, 0);
        cmp(voicing, 32'h00009000, 4);
        cmp(totalNoise, 32'hFFF471AE, 32768);
        cmp(nonStationarity, 32'h00008AE1, 6144);
        for (int i = 0; i < 20; i++) cmp(noiseBandFlat[i*32+:32], i == 5 ? 32'hE5 : 32'hCE, 2);
        frame(32'h001A0000, 8'd46, 8'd50, 1'b1, 1'b0, 1'b0);
        cmp(energyVariation, 32'h00060000, 0);
        cmp(upperEnvelope, 32'h001A0000, 0);
        cmp(residRatio, 32'h00000000, 0);
        cmp(nonStationarity, 32'h00006A3F, 6144);
        cmp(pitchStabilityCount, 32'd5, 0);
        cmp(noiseBandFlat[31:0], 32'hB9, 3);
    endtask
    task automatic t_track;
        frame(32'h001A0000, 8'd50, 8'd50, 1'b1, 1'b0, 1'b0);
        cmp(smoothEnergy, 32'h001A0000, 4);
        cmp(upperEnvelope, 32'h0019F5C3, 0);
        cmp(smoothVariation, 32'h0000199A, 0);
        cmp(lowerEnvelope, 32'h001A0000, 0);
        cmp(energyDynamics, 32'hFFFFFEFA, 8);
        cmp(longTermMin, 32'h001A0000, 4);
        cmp(pitchStabilityCount, 32'd0, 0);
    endtask
    task automatic t_narrow;
        frame(32'h00280000, 8'd50, 8'd50, 1'b0, 1'b0, 1'b1);
        cmp(pitchStabilityCount, 32'd12, 0);
        cmp(energyVariation, 32'h000E0000, 0);
        cmp(smoothVariation, 32'h00002873, 8);
        cmp(upperEnvelope, 32'h0019EB86, 1);
        cmp(lowerEnvelope, 32'h001A147B, 2);
        repeat (30) begin
            @(negedge clk);
            cmp(done, 0, 0);
        end
    endtask
    task automatic t_excess;
        frame(32'h00500000, 8'd56, 8'd62, 1'b1, 1'b0, 1'b0);
        cmp(lowerEnvelope, 32'h001A3D71, 4);
        cmp({pitchStabilityCount, pitchStable}, {10'd12, 1'b0}, 0);
        frame(32'h00500000, 8'd62, 8'd73, 1'b1, 1'b0, 1'b0);
        cmp(lowerEnvelope, 32'h00250E56, 64);
        cmp({pitchStabilityCount, pitchStable}, {10'd11, 1'b1}, 0);
    endtask
    initial begin
        repeat (8) @(negedge clk);
        reset = 1'b0;
        t_reset();
        t_init();
        t_track();
        t_narrow();
        t_excess();
        tally_and_finish();
    end
endmodule
